// >>> host_rx_endpoint_csr.sv
`timescale 1ns/1ps
`include "rx_csr_params.svh"
module host_rx_endpoint_csr
#(
    parameter int ADDR_WIDTH = 12,
    parameter int COUNT_WIDTH = 13
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Packet engine side
    input wire rx_csr_pkg::engine_event_type events,
    input wire logic [COUNT_WIDTH-1:0] engine_byte_count,
    output rx_csr_pkg::engine_ctrl_type ctrl,
    output logic [COUNT_WIDTH-1:0] rx_byte_count,
    output logic rx_byte_count_valid,
    // Interrupt
    output logic irq
);
    // ==========================================
    // Elaboration checks; the decoder compares twelve address bits
    generate
        if (ADDR_WIDTH < 12 || COUNT_WIDTH < 1 || COUNT_WIDTH > 16)
        begin : g_bad_params
            $error("host_rx_endpoint_csr: unsupported parameters");
        end
    endgenerate

    // ==========================================
    // Bus decode
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] ofs);
        hit = (a[11:0] == ofs);
    endfunction : hit

    logic wr_acc;
    logic low_lane;
    logic mapped;
    assign wr_acc = psel && penable && pwrite;
    assign low_lane = pstrb[0] && pstrb[1];
    assign mapped = hit(paddr, `OFS_CSR) || hit(paddr, `OFS_INT_STATUS)
        || hit(paddr, `OFS_INT_MASK) || hit(paddr, `OFS_CFG);
    // Zero wait states keeps the slave simple
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    logic csr_wr;
    logic ist_wr;
    logic msk_wr;
    logic cfg_wr;
    assign csr_wr = wr_acc && low_lane && hit(paddr, `OFS_CSR);
    assign ist_wr = wr_acc && pstrb[0] && hit(paddr, `OFS_INT_STATUS);
    assign msk_wr = wr_acc && pstrb[0] && hit(paddr, `OFS_INT_MASK);
    assign cfg_wr = wr_acc && pstrb[0] && hit(paddr, `OFS_CFG);

    // ==========================================
    // Control bits
    logic dma_en_r, dma_en_nxt;
    logic nyet_sup_r, nyet_sup_nxt;
    logic tog_wren_r, tog_wren_nxt;
    logic tog_r, tog_nxt;
    logic in_req_r, in_req_nxt;
    logic iso_r, iso_nxt;
    logic hs_r, hs_nxt;
    logic flush_r, flush_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic pkt_rdy;
    logic derr_iso_r, derr_iso_nxt;

    always_comb
    begin
        dma_en_nxt = dma_en_r;
        nyet_sup_nxt = nyet_sup_r;
        tog_wren_nxt = tog_wren_r;
        tog_nxt = tog_r;
        in_req_nxt = in_req_r;
        iso_nxt = iso_r;
        hs_nxt = hs_r;
        mask_nxt = mask_r;
        flush_nxt = 1'b0;
        if (csr_wr)
        begin
            dma_en_nxt = pwdata[`BIT_DMA_EN];
            nyet_sup_nxt = pwdata[`BIT_NYET_SUP];
            if (tog_wren_r)
            begin
                tog_nxt = pwdata[`BIT_TOG];
                tog_wren_nxt = 1'b0;
            end
            else
            begin
                tog_wren_nxt = pwdata[`BIT_TOG_WREN];
            end
            if (pwdata[`BIT_TOG_CLR])
            begin
                tog_nxt = 1'b0;
            end
            if (pwdata[`BIT_IN_REQ])
            begin
                in_req_nxt = 1'b1;
            end
            // Flush only when a packet is waiting
            flush_nxt = pwdata[`BIT_FLUSH] && pkt_rdy;
        end
        // Packet arrival retires the request and wins over a rewrite
        if (events.packet_done)
        begin
            in_req_nxt = 1'b0;
        end
        if (msk_wr)
        begin
            mask_nxt = pwdata[3:0];
        end
        if (cfg_wr)
        begin
            iso_nxt = pwdata[`CFG_ISO];
            hs_nxt = pwdata[`CFG_HS];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dma_en_r <= 1'b0;
            nyet_sup_r <= 1'b0;
            tog_wren_r <= 1'b0;
            tog_r <= 1'b0;
            in_req_r <= 1'b0;
            iso_r <= 1'b0;
            hs_r <= 1'b0;
            mask_r <= `IRQ_RESET;
            flush_r <= 1'b0;
        end
        else
        begin
            dma_en_r <= dma_en_nxt;
            nyet_sup_r <= nyet_sup_nxt;
            tog_wren_r <= tog_wren_nxt;
            tog_r <= tog_nxt;
            in_req_r <= in_req_nxt;
            iso_r <= iso_nxt;
            hs_r <= hs_nxt;
            mask_r <= mask_nxt;
            flush_r <= flush_nxt;
        end
    end

    // ==========================================
    // Hardware-set flags; set beats clear
    logic stall_q;
    logic nak_q;
    logic err_q;
    logic derr_set;
    logic pkt_clr;
    assign pkt_clr = (csr_wr && !pwdata[`BIT_PKT_RDY]) || flush_nxt;

    rx_flag_bit u_pkt
    (
        .clk(clk),
        .reset_n(reset_n),
        .set(events.packet_done),
        .clr(pkt_clr),
        .q(pkt_rdy)
    );

    rx_flag_bit u_stall
    (
        .clk(clk),
        .reset_n(reset_n),
        .set(events.stall_seen),
        .clr(csr_wr && !pwdata[`BIT_STALL]),
        .q(stall_q)
    );

    rx_flag_bit u_nak
    (
        .clk(clk),
        .reset_n(reset_n),
        .set(events.nak_timeout && !iso_r),
        .clr(csr_wr && !pwdata[`BIT_DERR]),
        .q(nak_q)
    );

    rx_flag_bit u_err
    (
        .clk(clk),
        .reset_n(reset_n),
        .set(events.retry_exhausted && !iso_r),
        .clr(csr_wr && !pwdata[`BIT_ERR]),
        .q(err_q)
    );

    // Iso data error rides on packet ready and falls with it
    assign derr_set = iso_r && events.packet_done && events.crc_error;
    always_comb
    begin
        derr_iso_nxt = derr_iso_r;
        if (pkt_clr)
        begin
            derr_iso_nxt = 1'b0;
        end
        if (derr_set)
        begin
            derr_iso_nxt = 1'b1;
        end
        else if (events.packet_done)
        begin
            derr_iso_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            derr_iso_r <= 1'b0;
        end
        else
        begin
            derr_iso_r <= derr_iso_nxt;
        end
    end

    // ==========================================
    // Interrupt status: write one to clear, set wins
    logic [3:0] ist_r, ist_nxt;
    logic [3:0] ev_vec;
    assign ev_vec[`IRQ_STALL] = events.stall_seen;
    assign ev_vec[`IRQ_PKT] = events.packet_done;
    assign ev_vec[`IRQ_ERR] = events.retry_exhausted && !iso_r;
    assign ev_vec[`IRQ_NAK] = events.nak_timeout && !iso_r;

    always_comb
    begin
        ist_nxt = ist_r;
        if (ist_wr)
        begin
            ist_nxt = ist_r & ~pwdata[3:0];
        end
        ist_nxt = ist_nxt | ev_vec;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ist_r <= `IRQ_RESET;
        end
        else
        begin
            ist_r <= ist_nxt;
        end
    end

    assign irq = |(ist_r & mask_r);

    // ==========================================
    // Outputs to the packet engine
    logic err_vis;
    logic derr_vis;
    assign err_vis = err_q && !iso_r;
    assign derr_vis = iso_r ? derr_iso_r : nak_q;

    always_comb
    begin
        ctrl.in_request = in_req_r;
        // Suppression only matters at high speed
        ctrl.send_ack_not_nyet = nyet_sup_r && hs_r;
        ctrl.flush_pulse = flush_r;
        ctrl.dma_req = dma_en_r && pkt_rdy;
        ctrl.rx_data_toggle = tog_r;
    end

    // Count is latched each cycle; forced to zero the cycle after packet ready drops
    logic [COUNT_WIDTH-1:0] cnt_r;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= pkt_rdy ? engine_byte_count : '0;
        end
    end
    assign rx_byte_count = cnt_r;
    assign rx_byte_count_valid = pkt_rdy;

    // ==========================================
    // Read data
    logic [15:0] csr_view;
    logic [31:0] rd_nxt;
    always_comb
    begin
        csr_view = `CSR_RESET;
        csr_view[`BIT_DMA_EN] = dma_en_r;
        csr_view[`BIT_NYET_SUP] = nyet_sup_r;
        csr_view[`BIT_TOG_WREN] = tog_wren_r;
        csr_view[`BIT_TOG] = tog_r;
        csr_view[`BIT_STALL] = stall_q;
        csr_view[`BIT_IN_REQ] = in_req_r;
        csr_view[`BIT_DERR] = derr_vis;
        csr_view[`BIT_ERR] = err_vis;
        csr_view[`BIT_FULL] = events.fifo_full;
        csr_view[`BIT_PKT_RDY] = pkt_rdy;
        rd_nxt = 32'h0000_0000;
        if (hit(paddr, `OFS_CSR))
        begin
            rd_nxt = {16'h0000, csr_view};
        end
        else if (hit(paddr, `OFS_INT_STATUS))
        begin
            rd_nxt = {28'h0000000, ist_r};
        end
        else if (hit(paddr, `OFS_INT_MASK))
        begin
            rd_nxt = {28'h0000000, mask_r};
        end
        else if (hit(paddr, `OFS_CFG))
        begin
            rd_nxt = {30'h0, hs_r, iso_r};
        end
    end
    // Setup-phase capture gives registered read data at the access phase
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            prdata <= rd_nxt;
        end
    end

    // ==========================================
    // Checks
    a_dma_gated: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl.dma_req |-> dma_en_r && pkt_rdy)
        else $error("dma request without enable");
    a_ack_hs_only: assert property (@(posedge clk) disable iff (!reset_n)
        !hs_r |-> !ctrl.send_ack_not_nyet)
        else $error("nyet suppress outside high speed");
    a_ack_follows: assert property (@(posedge clk) disable iff (!reset_n)
        (nyet_sup_r && hs_r) |-> ctrl.send_ack_not_nyet)
        else $error("ack not forced");
    a_wren_clears: assert property (@(posedge clk) disable iff (!reset_n)
        (csr_wr && tog_wren_r) |=> !tog_wren_r)
        else $error("toggle write enable stuck");
    a_tog_locked: assert property (@(posedge clk) disable iff (!reset_n)
        (!tog_wren_r && !(csr_wr && pwdata[`BIT_TOG_CLR])) |=> $stable(tog_r))
        else $error("toggle changed while locked");
    a_tog_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (csr_wr && pwdata[`BIT_TOG_CLR]) |=> !tog_r)
        else $error("toggle not cleared");
    a_stall_set: assert property (@(posedge clk) disable iff (!reset_n)
        events.stall_seen |=> stall_q && ist_r[`IRQ_STALL])
        else $error("stall not flagged");
    a_req_retire: assert property (@(posedge clk) disable iff (!reset_n)
        events.packet_done |=> !in_req_r && pkt_rdy)
        else $error("in request not retired");
    a_flush_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (flush_nxt && !events.packet_done) |=> !pkt_rdy ##1 !ctrl.flush_pulse)
        else $error("flush did not clear packet ready");
    a_flush_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (csr_wr && !pkt_rdy) |=> !ctrl.flush_pulse)
        else $error("flush without packet");
    a_derr_iso: assert property (@(posedge clk) disable iff (!reset_n)
        derr_set |=> derr_iso_r && pkt_rdy)
        else $error("iso data error missing");
    a_nak_set: assert property (@(posedge clk) disable iff (!reset_n)
        (events.nak_timeout && !iso_r) |=> nak_q)
        else $error("nak timeout not flagged");
    a_err_set: assert property (@(posedge clk) disable iff (!reset_n)
        (events.retry_exhausted && !iso_r) |=> err_q && ist_r[`IRQ_ERR])
        else $error("retry error not flagged");
    a_err_iso_zero: assert property (@(posedge clk) disable iff (!reset_n)
        iso_r |-> !csr_view[`BIT_ERR])
        else $error("retry error visible in iso");
    a_full_tracks: assert property (@(posedge clk) disable iff (!reset_n)
        csr_view[`BIT_FULL] == events.fifo_full)
        else $error("fifo full mismatch");
    a_pkt_irq: assert property (@(posedge clk) disable iff (!reset_n)
        (events.packet_done && mask_r[`IRQ_PKT] && !msk_wr) |=> irq)
        else $error("packet interrupt missing");
    a_cnt_valid: assert property (@(posedge clk) disable iff (!reset_n)
        !pkt_rdy |=> (rx_byte_count == '0) || pkt_rdy)
        else $error("count shown without packet");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
        csr_view[15:14] == 2'h0 && csr_view[11] == 1'b0 && csr_view[8] == 1'b0)
        else $error("reserved bits not zero");
endmodule : host_rx_endpoint_csr

// >>> rx_csr_params.svh
`ifndef RX_CSR_PARAMS_SVH
`define RX_CSR_PARAMS_SVH
// ==========================================
// Register byte offsets
`define OFS_CSR 12'h000
`define OFS_INT_STATUS 12'h004
`define OFS_INT_MASK 12'h008
`define OFS_CFG 12'h00C
// ==========================================
// Control/status field positions
`define BIT_DMA_EN 13
`define BIT_NYET_SUP 12
`define BIT_TOG_WREN 10
`define BIT_TOG 9
`define BIT_TOG_CLR 7
`define BIT_STALL 6
`define BIT_IN_REQ 5
`define BIT_FLUSH 4
`define BIT_DERR 3
`define BIT_ERR 2
`define BIT_FULL 1
`define BIT_PKT_RDY 0
// ==========================================
// Interrupt status positions
`define IRQ_STALL 0
`define IRQ_PKT 1
`define IRQ_ERR 2
`define IRQ_NAK 3
// ==========================================
// Config field positions
`define CFG_ISO 0
`define CFG_HS 1
// ==========================================
// Reset values
`define CSR_RESET 16'h0000
`define IRQ_RESET 4'h0
`endif

// >>> rx_csr_pkg.sv
package rx_csr_pkg;
    // ==========================================
    // Events reported by the packet engine
    typedef struct packed {
        logic stall_seen;
        logic packet_done;
        logic crc_error;
        logic nak_timeout;
        logic retry_exhausted;
        logic fifo_full;
    } engine_event_type;

    // Controls handed to the packet engine
    typedef struct packed {
        logic in_request;
        logic send_ack_not_nyet;
        logic flush_pulse;
        logic dma_req;
        logic rx_data_toggle;
    } engine_ctrl_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_SETUP,
        BUS_ACCESS
    } apb_phase_type;
endpackage : rx_csr_pkg

// >>> rx_flag_bit.sv
`timescale 1ns/1ps
// ==========================================
// Sticky flag: hardware set wins over clear
module rx_flag_bit
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic set,
    input wire logic clr,
    // State
    output logic q
);
    logic q_nxt;

    always_comb
    begin
        q_nxt = q;
        if (clr)
        begin
            q_nxt = 1'b0;
        end
        if (set)
        begin
            q_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= 1'b0;
        end
        else
        begin
            q <= q_nxt;
        end
    end
endmodule : rx_flag_bit

// >>> test_host_rx_endpoint_csr.sv
`timescale 1ns/1ps
`include "rx_csr_params.svh"
module test_host_rx_endpoint_csr;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rx_csr_pkg::engine_event_type events;
    rx_csr_pkg::engine_ctrl_type ctrl;
    logic [12:0] cnt_in = 13'h0000;
    logic [12:0] rx_byte_count;
    logic rx_byte_count_valid;
    logic irq;
    logic start = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [3:0] delay = 4'h0;
    logic full = 1'b0;
    logic perr;
    logic [31:0] rd;
    logic [11:0] ofs [4] = '{`OFS_CSR, `OFS_INT_STATUS, `OFS_INT_MASK, `OFS_CFG};
    int err_count = 0;
    int checks = 0;
    int flushes = 0;
    int seed = 28597;

    initial
    begin
        forever #4 clk = ~clk;
    end

    // Byte lanes all on: strobe refusal is not what this bench is after
    host_rx_endpoint_csr u_host_rx_endpoint_csr (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
        .engine_byte_count(cnt_in), .ctrl(ctrl), .rx_byte_count(rx_byte_count),
        .rx_byte_count_valid(rx_byte_count_valid), .irq(irq));
    usb_peer_model u_usb_peer_model (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .start(start),
        .kind(kind), .delay(delay), .full(full), .events(events));

    always @(posedge clk)
        if (ctrl.flush_pulse === 1'b1)
            flushes <= flushes + 1;

    // ==========================================
    // Tasks
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // Returns at the falling edge so that registered outputs have settled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk_reg(rd & m, exp);
    endtask : rd_chk

    function automatic logic [31:0] exp_flags(input logic [2:0] k, input logic iso);
        case (k)
            3'h0: return 32'h01;
            3'h1: return iso ? 32'h09 : 32'h01;
            3'h2: return 32'h40;
            3'h3: return iso ? 32'h00 : 32'h08;
            default: return iso ? 32'h00 : 32'h04;
        endcase
    endfunction : exp_flags

    function automatic logic [31:0] exp_int(input logic [2:0] k, input logic iso);
        case (k)
            3'h0, 3'h1: return 32'h2;
            3'h2: return 32'h1;
            3'h3: return iso ? 32'h0 : 32'h8;
            default: return iso ? 32'h0 : 32'h4;
        endcase
    endfunction : exp_int

    task automatic pulse(input logic [2:0] k, input logic [3:0] dl);
        @(posedge clk);
        start <= 1'b1;
        kind <= k;
        delay <= dl;
        cnt_in <= 13'($random(seed));
        @(posedge clk);
        start <= 1'b0;
    endtask : pulse

    // One peer event, checked, then cleaned up again
    task automatic ev(input logic [2:0] k, input logic iso, input logic [3:0] dl);
        logic [31:0] ef;
        logic [31:0] ei;
        int f0;
        ef = exp_flags(k, iso);
        ei = exp_int(k, iso);
        apb(1'b1, `OFS_CFG, {31'h0, iso});
        if (k < 3'h2)
        begin
            apb(1'b1, `OFS_CSR, 32'h2020);
            chk_bit(ctrl.in_request, 1'b1);
        end
        pulse(k, dl);
        repeat (20) @(posedge clk);
        rd_chk(`OFS_CSR, ef, 32'h6D);
        rd_chk(`OFS_INT_STATUS, ei, 32'hF);
        chk_bit(irq, ei != 32'h0);
        if (k < 3'h2)
        begin
            chk_reg({19'h0, rx_byte_count}, {19'h0, cnt_in});
            chk_bit(rx_byte_count_valid, 1'b1);
            chk_bit(ctrl.dma_req, 1'b1);
            f0 = flushes;
            apb(1'b1, `OFS_CSR, 32'h2010 | ef);
            rd_chk(`OFS_CSR, 32'h0, 32'h09);
            chk_reg(32'(flushes - f0), 32'h1);
            chk_bit(ctrl.dma_req, 1'b0);
            chk_bit(rx_byte_count_valid, 1'b0);
        end
        apb(1'b1, `OFS_CSR, 32'h0);
        rd_chk(`OFS_CSR, 32'h0, 32'h6D);
        apb(1'b1, `OFS_INT_STATUS, 32'hF);
        chk_bit(irq, 1'b0);
    endtask : ev

    // ==========================================
    // Main sequence
    initial
    begin
        int f0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        foreach (ofs[i]) rd_chk(ofs[i], 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 12'h010, 32'h0);
        chk_bit(perr, 1'b1);
        chk_reg(rd, 32'h0);
        apb(1'b1, `OFS_CSR, 32'hC900);
        rd_chk(`OFS_CSR, 32'h0, 32'hFFFFFFFF);
        apb(1'b1, `OFS_CSR, 32'h0200);
        rd_chk(`OFS_CSR, 32'h0, 32'h0200);
        apb(1'b1, `OFS_CSR, 32'h0400);
        apb(1'b1, `OFS_CSR, 32'h0600);
        rd_chk(`OFS_CSR, 32'h0200, 32'h0200);
        chk_bit(ctrl.rx_data_toggle, 1'b1);
        apb(1'b1, `OFS_CSR, 32'h0);
        rd_chk(`OFS_CSR, 32'h0200, 32'h0200);
        apb(1'b1, `OFS_CSR, 32'h0080);
        rd_chk(`OFS_CSR, 32'h0, 32'h0280);
        apb(1'b1, `OFS_INT_MASK, 32'hF);
        rd_chk(`OFS_INT_MASK, 32'hF, 32'hFFFFFFFF);
        for (int j = 0; j < 4; j++)
        begin
            apb(1'b1, `OFS_CFG, {30'h0, j[1], 1'b0});
            apb(1'b1, `OFS_CSR, {19'h0, j[0], 12'h000});
            chk_bit(ctrl.send_ack_not_nyet, j[0] & j[1]);
        end
        @(posedge clk);
        full <= 1'b1;
        rd_chk(`OFS_CSR, 32'h2, 32'h2);
        @(posedge clk);
        full <= 1'b0;
        apb(1'b1, `OFS_CSR, 32'h2);
        rd_chk(`OFS_CSR, 32'h0, 32'h2);
        f0 = flushes;
        apb(1'b1, `OFS_CSR, 32'h10);
        repeat (3) @(posedge clk);
        chk_reg(32'(flushes - f0), 32'h0);
        ev(3'h0, 1'b0, 4'h0);
        ev(3'h1, 1'b1, 4'hF);
        for (int k = 0; k < 10; k++)
            ev(3'(k / 2), 1'(k), 4'h3);
        repeat (8) ev(3'($unsigned($random(seed)) % 5), 1'($random(seed)), 4'($random(seed)));
        apb(1'b1, `OFS_INT_MASK, 32'h0);
        pulse(3'h2, 4'h0);
        // Let the peer fire and the status register take the event
        repeat (4) @(posedge clk);
        rd_chk(`OFS_INT_STATUS, 32'h1, 32'hF);
        chk_bit(irq, 1'b0);
        apb(1'b1, `OFS_INT_MASK, 32'h1);
        chk_bit(irq, 1'b1);
        apb(1'b1, `OFS_INT_STATUS, 32'h1);
        chk_bit(irq, 1'b0);
        finish_test();
    end

    // Whole run needs under ten microseconds; this limit leaves ample margin
    initial
    begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule : test_host_rx_endpoint_csr

// >>> usb_peer_model.sv
`timescale 1ns/1ps
// ==========================================
// Far-side peripheral: answers host tokens with one event after a programmable wait
module usb_peer_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host side
    input wire rx_csr_pkg::engine_ctrl_type ctrl,
    // Scenario control
    input wire logic start,
    input wire logic [2:0] kind,
    input wire logic [3:0] delay,
    input wire logic full,
    // Events
    output rx_csr_pkg::engine_event_type events
);
    logic busy_r;
    logic [2:0] kind_r;
    logic [3:0] wait_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_r <= 1'b0;
            kind_r <= 3'h0;
            wait_r <= 4'h0;
            events <= '0;
        end
        else
        begin
            events <= '0;
            events.fifo_full <= full;
            if (start)
            begin
                busy_r <= 1'b1;
                kind_r <= kind;
                wait_r <= delay;
            end
            else if (busy_r && wait_r != 4'h0)
            begin
                wait_r <= wait_r - 4'h1;
            end
            // Data never leaves the peer without an IN token, so data kinds wait for it
            else if (busy_r && (kind_r > 3'h1 || ctrl.in_request))
            begin
                busy_r <= 1'b0;
                events.packet_done <= (kind_r <= 3'h1);
                events.crc_error <= (kind_r == 3'h1);
                events.stall_seen <= (kind_r == 3'h2);
                events.nak_timeout <= (kind_r == 3'h3);
                events.retry_exhausted <= (kind_r == 3'h4);
            end
        end
    end
endmodule : usb_peer_model
